// [core/asp_baud_gen.sv]
// asp_baud_gen: fractional divider making the 16x oversampling tick
// assumes modulo and frac are held steady while the port runs
`timescale 1ns/100ps
module asp_baud_gen
    import asp_pkg::*;
(
    input wire logic mclk_in,
    input wire logic arst_n_in,
    asp_baud_if.gen bif
);
    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    typedef struct packed {
        logic [MOD_W-1:0] cnt; // clocks since last tick
        logic [FRAC_W-1:0] acc; // fractional accumulator
        logic ext; // stretch this period by one clock
        logic tick; // registered tick
    } asp_bg_st_type;

    asp_bg_st_type q, d;
    logic [FRAC_W:0] sum; // accumulator plus fraction with carry
    logic at_end; // period complete

    assign bif.tick = q.tick;

    // next-state: period is modulo clocks, plus one when the fraction carries
    always_comb
    begin
        d = q;
        d.tick = 1'b0;
        sum = {1'b0, q.acc} + {1'b0, bif.frac};
        at_end = ({1'b0, q.cnt} + 14'h0001) == ({1'b0, bif.modulo} + {13'h0000, q.ext});
        if (!bif.enable || bif.modulo == 13'h0000) // runs on peripheral clock
        begin
            d.cnt = '0;
            d.acc = '0;
            d.ext = 1'b0;
        end
        else if (at_end) // modulo 1 ticks every clock: 16 MHz gives 1 Mbps
        begin
            d.cnt = '0;
            d.tick = 1'b1;
            d.acc = sum[FRAC_W-1:0];
            d.ext = sum[FRAC_W]; // averaging spreads the fraction
        end
        else
        begin
            d.cnt = q.cnt + 13'h0001;
        end
    end

    // register the whole state
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end
endmodule

// [core/asp_top.sv]
// asp_top: full-duplex async serial port with shared fractional baud clock
// assumes rxd_in is asynchronous; all control ports are on mclk_in
`timescale 1ns/100ps
module asp_top
    import asp_pkg::*;
(
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic rxd_in,
    output logic txd_out,
    input wire logic [MOD_W-1:0] baud_mod_in,
    input wire logic [FRAC_W-1:0] baud_frac_in,
    input wire logic tx_en_in,
    input wire logic rx_en_in,
    input wire logic nine_bit_in,
    input wire logic parity_en_in,
    input wire logic parity_odd_in,
    input wire logic tx_invert_in,
    input wire logic brk_detect_en_in,
    input wire logic send_break_in,
    input wire logic sleep_req_in,
    input wire logic wake_addr_in,
    input wire logic [DATA_W-1:0] tx_data_in,
    input wire logic tx_write_in,
    input wire logic rx_read_in,
    input wire logic [FLAG_W-1:0] flag_clr_in,
    input wire logic [FLAG_W-1:0] irq_en_in,
    output logic [DATA_W-1:0] rx_data_out,
    output logic [FLAG_W-1:0] flags_out,
    output logic rx_asleep_out,
    output logic irq_out
);
    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    typedef struct packed {
        logic s1; // synchroniser first stage
        logic s2; // synchronised receive line
        logic rx_prev; // previous line level for edges
        asp_rx_st_type rst; // receiver state
        logic [3:0] rph; // tick within bit
        logic [3:0] ridx; // bit within frame
        logic [2:0] smp; // three mid-bit samples
        logic noise; // disagreement seen in frame
        logic par_bad; // parity mismatch in frame
        logic [DATA_W-1:0] rsh; // receive shifter
        logic [DATA_W-1:0] rbuf; // receive buffer
        logic [7:0] low_cnt; // ticks of continuous space
        logic brk_seen; // break already flagged this run
        logic [7:0] idle_cnt; // ticks of continuous mark
        logic idle_arm; // idle may be flagged once
        logic asleep; // receiver waiting for wake
        asp_tx_st_type tst; // transmitter state
        logic [3:0] tph; // tick within bit
        logic [3:0] tidx; // bit within frame
        logic [11:0] tsh; // transmit shifter, lsb on line
        logic [DATA_W-1:0] tbuf; // transmit buffer
        logic brk_req; // break queued
        logic txpin; // pin level after polarity
        logic [FLAG_W-1:0] flags; // sticky status
        logic irq; // registered interrupt
    } asp_st_type;

    asp_st_type q, d;
    asp_baud_if bif ();
    logic [FLAG_W-1:0] set_v; // flags raised this cycle
    logic [FLAG_W-1:0] clr_v; // flags cleared this cycle
    logic [3:0] nd; // data bits per character
    logic [3:0] last_idx; // index of the stop bit
    logic [7:0] char_ticks; // ticks per character
    logic maj; // majority of samples
    logic dis; // samples disagree
    logic abit; // address-mark bit of received word
    logic take; // received word goes to buffer
    logic pbit; // transmit parity bit
    logic line; // unpolarised transmit level
    logic [11:0] fr; // transmit frame image
    logic [DATA_W-1:0] dmask; // data mask for 8 or 9 bits

    asp_baud_gen u_baud (
        .mclk_in(mclk_in),
        .arst_n_in(arst_n_in),
        .bif(bif)
    );

    assign bif.modulo = baud_mod_in;
    assign bif.frac = baud_frac_in;
    assign bif.enable = tx_en_in | rx_en_in;
    assign txd_out = q.txpin;
    assign rx_data_out = q.rbuf;
    assign flags_out = q.flags;
    assign rx_asleep_out = q.asleep;
    assign irq_out = q.irq;

    // -------------------------------------------------------------------
    // next-state logic
    // -------------------------------------------------------------------
    always_comb
    begin
        d = q;
        set_v = '0;
        clr_v = flag_clr_in & SW_CLR_MASK;
        nd = nine_bit_in ? BITS_9 : BITS_8;
        dmask = nine_bit_in ? 9'h1FF : 9'h0FF;
        last_idx = nd + {3'h0, parity_en_in} + 4'h1;
        char_ticks = {last_idx + 4'h1, 4'h0};
        maj = (q.smp[0] & q.smp[1]) | (q.smp[0] & q.smp[2]) | (q.smp[1] & q.smp[2]);
        dis = (|q.smp) & ~(&q.smp);
        abit = nine_bit_in ? q.rsh[8] : q.rsh[7];
        take = !q.asleep || (wake_addr_in && abit);
        pbit = (^q.tbuf) ^ parity_odd_in;
        // frame image from the buffer: stop high, parity, data, start low
        fr = {2'b11, q.tbuf, 1'b0};
        if (!nine_bit_in)
        begin
            fr[9] = 1'b1;
        end
        if (parity_en_in)
        begin
            fr[nd + 4'h1] = pbit;
        end
        line = 1'b1;

        // synchroniser; only the second stage is looked at
        d.s1 = rxd_in;
        d.s2 = q.s1;
        d.rx_prev = q.s2;

        // falling edge on the line; only flagged, it does not wake the receiver
        if (rx_en_in && q.rx_prev && !q.s2)
        begin
            set_v[F_EDGE] = 1'b1;
        end

        // sleep request; a wake later in this process overrides it
        if (sleep_req_in)
        begin
            d.asleep = 1'b1;
        end

        // break: count space ticks independently of framing
        if (bif.tick)
        begin
            if (q.s2)
            begin
                d.low_cnt = '0;
                d.brk_seen = 1'b0;
            end
            else if (q.low_cnt != 8'hFF)
            begin
                d.low_cnt = q.low_cnt + 8'h01;
            end
            if (!q.s2 && brk_detect_en_in && rx_en_in && !q.brk_seen
                && q.low_cnt == BRK_RX_TICKS - 8'h01)
            begin
                set_v[F_BREAK] = 1'b1;
                d.brk_seen = 1'b1;
            end
        end

        // idle: one character time of mark after activity
        if (bif.tick)
        begin
            if (!q.s2)
            begin
                d.idle_cnt = '0;
            end
            else if (q.idle_arm)
            begin
                if (q.idle_cnt == char_ticks - 8'h01)
                begin
                    d.idle_arm = 1'b0;
                    if (!q.asleep)
                    begin
                        set_v[F_IDLE] = 1'b1;
                    end
                    else if (!wake_addr_in)
                    begin
                        d.asleep = 1'b0; // idle-line wake
                    end
                end
                else
                begin
                    d.idle_cnt = q.idle_cnt + 8'h01;
                end
            end
        end

        // receiver, independent of the transmitter
        case (q.rst)
            RX_IDLE:
            begin
                if (rx_en_in && bif.tick && !q.s2) // start edge
                begin
                    d.rst = RX_BUSY;
                    d.rph = 4'h1;
                    d.ridx = '0;
                    d.noise = 1'b0;
                    d.par_bad = 1'b0;
                    d.idle_arm = 1'b1;
                    d.idle_cnt = '0;
                end
            end
            default:
            begin
                if (!rx_en_in)
                begin
                    d.rst = RX_IDLE;
                end
                else if (bif.tick)
                begin
                    d.rph = q.rph + 4'h1;
                    if (q.rph >= SMP_FIRST && q.rph <= SMP_LAST)
                    begin
                        d.smp = {q.smp[1:0], q.s2};
                    end
                    if (q.rph == OS_LAST)
                    begin
                        d.ridx = q.ridx + 4'h1;
                        d.noise = q.noise | dis;
                        if (q.ridx == 4'h0)
                        begin
                            // start bit not low at mid-bit: glitch, drop it
                            if (maj)
                            begin
                                d.rst = RX_IDLE;
                            end
                        end
                        else if (q.ridx <= nd)
                        begin
                            d.rsh[q.ridx - 4'h1] = maj; // lsb first
                        end
                        else if (q.ridx != last_idx)
                        begin
                            d.par_bad = maj != ((^(q.rsh & dmask)) ^ parity_odd_in);
                        end
                        else
                        begin
                            d.rst = RX_IDLE;
                            if (take)
                            begin
                                d.asleep = 1'b0;
                                if (q.flags[F_RXFULL])
                                begin
                                    set_v[F_OVERRUN] = 1'b1; // buffer kept
                                end
                                else
                                begin
                                    d.rbuf = q.rsh & dmask;
                                    set_v[F_RXFULL] = 1'b1;
                                    set_v[F_NOISE] = q.noise | dis;
                                    set_v[F_PARITY] = q.par_bad & parity_en_in;
                                    set_v[F_FRAMING] = ~maj;
                                end
                            end
                        end
                    end
                end
            end
        endcase

        // software reads of the receive buffer clear its full flag with its errors; rbuf keeps the word
        if (rx_read_in)
        begin
            clr_v = clr_v | RD_CLR_MASK;
        end

        // transmit buffer write, refused while the buffer is occupied
        if (tx_write_in && q.flags[F_TXEMPTY])
        begin
            d.tbuf = tx_data_in & dmask;
            clr_v[F_TXEMPTY] = 1'b1;
            clr_v[F_TXDONE] = 1'b1;
        end
        if (send_break_in)
        begin
            d.brk_req = 1'b1;
        end

        // transmitter
        case (q.tst)
            TX_IDLE:
            begin
                if (tx_en_in && q.brk_req)
                begin
                    d.tst = TX_BREAK;
                    d.tph = '0;
                    d.tidx = '0;
                    d.brk_req = 1'b0;
                end
                else if (tx_en_in && !q.flags[F_TXEMPTY])
                begin
                    d.tst = TX_SHIFT;
                    d.tph = '0;
                    d.tidx = '0;
                    set_v[F_TXEMPTY] = 1'b1; // buffer free again
                    // shifter reloads only here, so a queued word never cuts a frame
                    d.tsh = fr;
                end
            end
            TX_SHIFT:
            begin
                if (!tx_en_in)
                begin
                    d.tst = TX_IDLE;
                end
                else if (bif.tick)
                begin
                    d.tph = q.tph + 4'h1;
                    if (q.tph == OS_LAST)
                    begin
                        d.tsh = {1'b1, q.tsh[11:1]};
                        d.tidx = q.tidx + 4'h1;
                        if (q.tidx == last_idx)
                        begin
                            d.tst = TX_IDLE;
                            // a write taken in this very cycle keeps done low
                            set_v[F_TXDONE] = q.flags[F_TXEMPTY] & ~tx_write_in;
                        end
                    end
                end
            end
            default:
            begin
                if (!tx_en_in)
                begin
                    d.tst = TX_IDLE;
                end
                else if (bif.tick)
                begin
                    d.tph = q.tph + 4'h1;
                    if (q.tph == OS_LAST)
                    begin
                        d.tidx = q.tidx + 4'h1;
                        if (q.tidx == BRK_TX_BITS - 4'h1)
                        begin
                            d.tst = TX_IDLE;
                        end
                    end
                end
            end
        endcase

        // line level: mark when idle, space during break, else shifter
        if (d.tst == TX_SHIFT)
        begin
            line = d.tsh[0];
        end
        else if (d.tst == TX_BREAK)
        begin
            line = 1'b0;
        end
        d.txpin = line ^ tx_invert_in;

        // set wins over clear so no event is lost
        d.flags = (q.flags & ~clr_v) | set_v;
        d.irq = |(q.flags & irq_en_in);
    end

    // -------------------------------------------------------------------
    // state register
    // -------------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            q <= '0;
            q.s1 <= 1'b1;
            q.s2 <= 1'b1;
            q.rx_prev <= 1'b1;
            q.tsh <= '1;
            q.txpin <= 1'b1;
            q.flags <= FLAGS_RST;
        end
        else
        begin
            q <= d;
        end
    end
endmodule

// [pkg/asp_baud_if.sv]
// asp_baud_if: carries baud settings to the generator and its tick back
// assumes both ends sit on the same peripheral clock
`timescale 1ns/100ps
interface asp_baud_if;
    logic [12:0] modulo; // whole clocks per tick, 0 stops the generator
    logic [4:0] frac; // fraction of a clock per tick, in 32nds
    logic enable; // generator runs while set
    logic tick; // one-cycle pulse at 16x bit rate
    modport gen (input modulo, input frac, input enable, output tick);
    modport user (output modulo, output frac, output enable, input tick);
endinterface

// [pkg/asp_pkg.sv]
// asp_pkg: constants, flag layout and state types for the async serial port
// assumes one peripheral clock domain; all users import asp_pkg::*
// Contract
// - one frac baud generator, 13-bit plus 5-bit
// - reaches 1 Mbps from 16 MHz clock
// - full duplex NRZ on separate pins
// - buffered word per direction, own enables
// - flags for buffer free and shifter done
// - flag when received word reaches buffer
// - overrun, parity, framing, noise error flags
// - multiple samples per bit, noise detect
// - flag active edge on receive pin
// - detect and flag line break
// - hardware parity generate and check
// - eight or nine data bits selectable
// - sleeping receiver wakes on idle or address
// - send 13-bit break, detect 11-bit break
// - transmit pin polarity invertible
// - baud fed by peripheral clock
// - receive activity flags asynchronous wake; code only sets F_EDGE through the mclk_in synchroniser
package asp_pkg;
    // -------------------------------------------------------------------
    // clock and widths
    // -------------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000; // peripheral clock rate
    localparam int MOD_W = 13; // baud modulo counter width
    localparam int FRAC_W = 5; // baud fraction width
    localparam int DATA_W = 9; // widest character
    localparam int FLAG_W = 10; // number of status flags

    // -------------------------------------------------------------------
    // oversampling and break lengths
    // -------------------------------------------------------------------
    localparam logic [3:0] OS_LAST = 4'hF; // last of 16 ticks per bit
    localparam logic [3:0] SMP_FIRST = 4'h7; // first of three samples
    localparam logic [3:0] SMP_LAST = 4'h9; // last of three samples
    localparam logic [3:0] BRK_TX_BITS = 4'hD; // 13 bit times of space
    localparam logic [7:0] BRK_RX_TICKS = 8'hB0; // 11 bit times of 16 ticks
    localparam logic [3:0] BITS_8 = 4'h8; // short character
    localparam logic [3:0] BITS_9 = 4'h9; // long character

    // -------------------------------------------------------------------
    // flag vector layout
    // -------------------------------------------------------------------
    localparam int F_TXEMPTY = 0; // transmit buffer free
    localparam int F_TXDONE = 1; // shifter idle, nothing queued
    localparam int F_RXFULL = 2; // receive buffer holds a word
    localparam int F_OVERRUN = 3;
    localparam int F_PARITY = 4;
    localparam int F_FRAMING = 5;
    localparam int F_NOISE = 6;
    localparam int F_IDLE = 7;
    localparam int F_EDGE = 8;
    localparam int F_BREAK = 9;
    localparam logic [FLAG_W-1:0] FLAGS_RST = 10'h003; // both tx flags set
    localparam logic [FLAG_W-1:0] SW_CLR_MASK = 10'h382; // done, idle, edge, break
    localparam logic [FLAG_W-1:0] RD_CLR_MASK = 10'h07C; // full and errors

    // -------------------------------------------------------------------
    // state machines
    // -------------------------------------------------------------------
    typedef enum logic [0:0] {RX_IDLE = 1'b0, RX_BUSY = 1'b1} asp_rx_st_type;
    typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_SHIFT = 2'b01, TX_BREAK = 2'b10}
        asp_tx_st_type;
endpackage

// [verification/asp_properties.sv]
// asp_properties: port checker for asp_top
// assumes a bind onto asp_top, single clock
`timescale 1ns/100ps
module asp_properties
    import asp_pkg::*;
(
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic tx_write_in,
    input wire logic rx_read_in,
    input wire logic nine_bit_in,
    input wire logic [FLAG_W-1:0] irq_en_in,
    input wire logic [FLAG_W-1:0] flags_out,
    input wire logic [DATA_W-1:0] rx_data_out,
    input wire logic irq_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!arst_n_in);
    // irq is the masked flag OR, one clock late
    chk_irq_mask: assert property (1 |=> irq_out == |($past(flags_out & irq_en_in)))
        else $error("irq does not follow masked flags");
    chk_write_taken: assert property (tx_write_in && flags_out[F_TXEMPTY]
        |=> !flags_out[F_TXEMPTY] && !flags_out[F_TXDONE])
        else $error("accepted write left tx flags set");
    chk_empty_cause: assert property ($fell(flags_out[F_TXEMPTY]) |-> $past(tx_write_in))
        else $error("tx empty fell without write");
    chk_load_busy: assert property ($rose(flags_out[F_TXEMPTY]) |-> !flags_out[F_TXDONE])
        else $error("shifter loaded but done set");
    chk_full_cause: assert property ($fell(flags_out[F_RXFULL]) |-> $past(rx_read_in))
        else $error("rx full fell without read");
    chk_overrun_full: assert property ($rose(flags_out[F_OVERRUN]) |-> flags_out[F_RXFULL])
        else $error("overrun without full buffer");
    chk_data_held: assert property ($changed(rx_data_out) |-> flags_out[F_RXFULL])
        else $error("rx data moved without full");
    chk_short_top: assert property (!nine_bit_in && flags_out[F_RXFULL] |-> !rx_data_out[8])
        else $error("bit 8 set in 8-bit mode");
    chk_err_with_full: assert property ($rose(|flags_out[6:4]) |-> flags_out[F_RXFULL])
        else $error("error flag without word");
endmodule
bind asp_top asp_properties i_props (.mclk_in, .arst_n_in, .tx_write_in, .rx_read_in,
    .nine_bit_in, .irq_en_in, .flags_out, .rx_data_out, .irq_out);

// [verification/asp_remote.sv]
// asp_remote: far-end serial port, behavioural
// assumes a fixed bit time matching the bench's baud setting
`timescale 1ns/100ps
module asp_remote (
    input wire logic line_in,
    output logic line_out
);
    int bit_ns = 6400; // bit time in ns
    initial line_out = 1'b1; // line idles high
    // start, n bits lsb first, stop; g picks a bit to glitch
    task automatic send(input logic [9:0] b, input int n, input logic stop, input int g);
        line_out = 1'b0;
        #(bit_ns);
        for (int i = 0; i < n; i++)
        begin
            line_out = b[i];
            if (i == g)
            begin
                #(bit_ns / 2 - 200) line_out = ~b[i];
                #400 line_out = b[i];
                #(bit_ns / 2 - 200);
            end
            else
                #(bit_ns);
        end
        line_out = stop;
        #(bit_ns);
        line_out = 1'b1;
    endtask
    // samples bit centres, stop bit last
    task automatic catch(input int n, output logic [10:0] v);
        v = '0;
        @(negedge line_in);
        #(bit_ns / 2);
        for (int i = 0; i <= n; i++)
        begin
            #(bit_ns);
            v[i] = line_in;
        end
    endtask
    task automatic hold_low(input int ns);
        line_out = 1'b0;
        #(ns);
        line_out = 1'b1;
    endtask
    task automatic low_len(output int ns);
        time t;
        @(negedge line_in);
        t = $time;
        @(posedge line_in);
        ns = int'($time - t);
    endtask
endmodule

// [verification/asp_top_tb_top.sv]
// asp_top_tb_top: directed bench for asp_top
// assumes asp_remote on the serial pins, 64-clock bits
`timescale 1ns/100ps
module asp_top_tb_top
    import asp_pkg::*;
;
    logic mclk_in, arst_n_in, rxd_in, txd_out, tx_en_in, rx_en_in, nine_bit_in;
    logic parity_en_in, parity_odd_in, tx_invert_in, brk_detect_en_in, send_break_in;
    logic sleep_req_in, wake_addr_in, tx_write_in, rx_read_in, rx_asleep_out, irq_out;
    logic [MOD_W-1:0] baud_mod_in;
    logic [FRAC_W-1:0] baud_frac_in;
    logic [DATA_W-1:0] tx_data_in, rx_data_out;
    logic [FLAG_W-1:0] flag_clr_in, irq_en_in, flags_out;
    logic [10:0] got;
    int err_total, compares, cyc, len;
    asp_top i_dut (.*);
    asp_remote i_rem (.line_in(txd_out), .line_out(rxd_in));
    initial
    begin
        mclk_in = 1'b0;
        forever #50 mclk_in = ~mclk_in;
    end
    // inputs move 10 ns after an edge, away from sampling
    task automatic step(input int n);
        repeat (n) @(posedge mclk_in);
        #10;
    endtask
    task automatic chk(input logic [10:0] g, input logic [10:0] e);
        compares++;
        if (g !== e)
        begin
            err_total++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic results;
        if (err_total == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic rd;
        rx_read_in = 1'b1;
        step(1);
        rx_read_in = 1'b0;
    endtask
    // one 8-bit frame with even parity, optionally wrong
    task automatic rx1(input logic [7:0] d, input logic bad, input logic stop, input int g);
        i_rem.send({1'b0, ^d ^ bad, d}, 9, stop, g);
        step(16);
    endtask
    // both directions at once over every length and parity mode
    task automatic t_frames;
        logic [8:0] d;
        logic [10:0] b;
        int n;
        for (int c = 0; c < 4; c++)
        begin
            {nine_bit_in, parity_odd_in, parity_en_in} = {c[1], c[1], c[0]};
            d = 9'h1A5 ^ 9'(c * 55);
            if (!c[1])
                d[8] = 1'b0;
            n = 8 + c[1];
            b = {2'b00, d};
            b[n] = ^d ^ c[1];
            n = n + c[0];
            b[n] = 1'b1;
            fork
                i_rem.send(b[9:0], n, 1'b1, 99);
                i_rem.catch(n, got);
                begin
                    tx_data_in = d;
                    tx_write_in = 1'b1;
                    step(1);
                    tx_write_in = 1'b0;
                    chk(flags_out[1:0], 2'b00);
                end
            join
            chk(got, b);
            step(40);
            chk(flags_out[2:0], 3'b111);
            chk(rx_data_out, d);
            chk(flags_out[6:3], 4'h0);
            rd;
        end
    endtask
    // second word queued while the first is on the line
    task automatic t_b2b;
        logic [10:0] g2;
        {nine_bit_in, parity_en_in} = 2'b00;
        fork
            begin
                i_rem.catch(8, got);
                i_rem.catch(8, g2);
            end
            begin
                tx_data_in = 9'h0C3;
                tx_write_in = 1'b1;
                step(1);
                tx_write_in = 1'b0;
                step(2);
                tx_data_in = 9'h05A;
                tx_write_in = 1'b1;
                step(1);
                tx_write_in = 1'b0;
            end
        join
        chk(got, 11'h1C3);
        chk(g2, 11'h15A);
    endtask
    task automatic t_errs;
        {nine_bit_in, parity_en_in, parity_odd_in} = 3'b010;
        rx1(8'h3C, 1'b1, 1'b1, 99);
        chk(flags_out[6:2], 5'h05);
        rd;
        rx1(8'h3C, 1'b0, 1'b0, 99);
        chk(flags_out[6:2], 5'h09);
        rd;
        rx1(8'h5A, 1'b0, 1'b1, 2);
        chk({flags_out[6:2], rx_data_out[7:0]}, 13'h115A);
        rd;
        rx1(8'h11, 1'b0, 1'b1, 99);
        rx1(8'h22, 1'b0, 1'b1, 99);
        chk({flags_out[6:2], rx_data_out[7:0]}, 13'h0311);
        rd;
        chk(flags_out[6:2], 5'h00);
        step(800);
        chk(flags_out[8:7], 2'b11);
        flag_clr_in = 10'h3FF;
        step(1);
        flag_clr_in = 10'h000;
        chk(flags_out, 10'h001);
        irq_en_in = 10'h001;
        step(3);
        chk(irq_out, 1'b1);
        irq_en_in = 10'h000;
        step(3);
        chk(irq_out, 1'b0);
    endtask
    // break both ways; tx side on a fractional rate of 4.5 clocks a tick
    task automatic t_break;
        brk_detect_en_in = 1'b1;
        i_rem.hold_low(76800);
        chk(flags_out[9], 1'b1);
        step(800);
        rd;
        baud_frac_in = 5'h10;
        fork
            i_rem.low_len(len);
            begin
                send_break_in = 1'b1;
                step(1);
                send_break_in = 1'b0;
            end
        join
        chk(len >= 93150 && len <= 94050, 1'b1);
        baud_frac_in = 5'h00;
        step(200);
    endtask
    task automatic t_sleep;
        wake_addr_in = 1'b1;
        sleep_req_in = 1'b1;
        step(1);
        sleep_req_in = 1'b0;
        step(1);
        chk(rx_asleep_out, 1'b1);
        rx1(8'h05, 1'b0, 1'b1, 99);
        chk(flags_out[2], 1'b0);
        rx1(8'h85, 1'b0, 1'b1, 99);
        chk({rx_asleep_out, flags_out[2], rx_data_out}, 11'h285);
        tx_invert_in = 1'b1;
        step(2);
        chk(txd_out, 1'b0);
    endtask
    always @(posedge mclk_in)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            err_total++;
            results;
        end
    end
    initial
    begin
        {arst_n_in, tx_write_in, rx_read_in, send_break_in, sleep_req_in} = '0;
        {nine_bit_in, parity_en_in, parity_odd_in, tx_invert_in} = '0;
        {brk_detect_en_in, wake_addr_in, tx_en_in, rx_en_in} = 4'h3;
        baud_mod_in = 13'h0004;
        baud_frac_in = 5'h00;
        tx_data_in = '0;
        flag_clr_in = '0;
        irq_en_in = '0;
        step(8);
        arst_n_in = 1'b1;
        step(1);
        chk({txd_out, flags_out}, 11'h403);
        t_frames;
        t_b2b;
        t_errs;
        t_break;
        t_sleep;
        results;
    end
endmodule
